// *** hw/pdmc_pkg.sv ***
// Package of constants and carriers for the power-down mode controller
package pdmc_pkg;
	localparam int SETTLE_SEL_W = 3;
	localparam int SETTLE_CNT_W = 18;
	localparam int KEY_W = 8;
	localparam int IRQ_W = 3;
	localparam logic [SETTLE_SEL_W-1:0] SETTLE_SEL_RST = 3'h0;
	localparam logic [SETTLE_CNT_W-1:0] SETTLE_STATES_0 = 18'h02000;
	localparam logic [SETTLE_CNT_W-1:0] SETTLE_STATES_1 = 18'h04000;
	localparam logic [SETTLE_CNT_W-1:0] SETTLE_STATES_2 = 18'h08000;
	localparam logic [SETTLE_CNT_W-1:0] SETTLE_STATES_3 = 18'h10000;
	localparam logic [SETTLE_CNT_W-1:0] SETTLE_STATES_4 = 18'h20000;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [4:0] {
		PDMC_RUN = 5'h01,
		PDMC_SLEEP = 5'h02,
		PDMC_SW_STANDBY = 5'h04,
		PDMC_SETTLE = 5'h08,
		PDMC_HW_STANDBY = 5'h10
	} pdmc_state_e;

	// Wake sources sampled from pins
	typedef struct packed {
		logic nmi_n;
		logic [IRQ_W-1:0] irq_n;
		logic [KEY_W-1:0] key_n;
		logic chip_init_n;
		logic hw_standby_n;
	} pdmc_pins_s;

	// Controls handed to the rest of the chip
	typedef struct packed {
		logic clk_run;
		logic cpu_halt;
		logic cpu_regs_keep;
		logic mod_clk_run;
		logic mod_init;
		logic ports_hiz;
		logic reset_seq;
	} pdmc_ctl_s;
endpackage : pdmc_pkg

// *** hw/pdmc_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pdmc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);
	logic [W-1:0] s1_q, s2_q, s3_q, out_q;
	logic [W-1:0] s1_d, s2_d, s3_d, out_d;

	always_comb begin
		s1_d = pin_in;
		s2_d = s1_q;
		s3_d = s2_q;
		out_d = out_q;
		// A change counts only once the last two stages agree
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			out_q <= INIT;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			out_q <= out_d;
		end
	end

	assign pin_out = out_q;
endmodule : pdmc_sync

// *** hw/pdmc_ctrl.sv ***
// Power-down mode controller: sleep, software standby and hardware standby
// Function
// - Three low-power modes: sleep, software, hardware standby
// - Halt with select clear enters sleep
// - Sleep exits on interrupt, init or standby pin
// - Select set plus halt enters software standby
// - Software standby stops clock, initialises modules
// - Software standby exits on NMI, IRQ, keys, pins
// - Standby pin low forces hardware standby
// - Hardware standby loses CPU state, ports high-Z while standby pin low
// - Leave hardware standby: pin high, init pulse
// - Select bit chooses sleep or software standby
// - Settle field sets wake delay in states
// - Select bit stays set after interrupt wake
// - Init pin in standby restarts oscillator, then reset
`timescale 1ns/1ps
module pdmc_ctrl (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic halt_exec,
	input wire logic irq_pending,
	input wire logic select_wr,
	input wire logic select_wdata,
	input wire logic [pdmc_pkg::SETTLE_SEL_W-1:0] settle_sel_wdata,
	input wire logic nmi_pin_n,
	input wire logic [pdmc_pkg::IRQ_W-1:0] irq_pin_n,
	input wire logic [pdmc_pkg::KEY_W-1:0] key_sense_inputs,
	input wire logic chip_init_pin_n,
	input wire logic hw_standby_pin_n,
	output logic standby_select_bit,
	output logic [pdmc_pkg::SETTLE_SEL_W-1:0] wake_settle_select,
	output pdmc_pkg::pdmc_ctl_s ctl,
	output pdmc_pkg::pdmc_state_e mode,
	output logic wake_irq
);
	localparam int PW = 1 + pdmc_pkg::IRQ_W + pdmc_pkg::KEY_W + 2;

	pdmc_pkg::pdmc_pins_s pins_raw, pins;
	pdmc_pkg::pdmc_state_e state_q, state_d;
	logic [pdmc_pkg::SETTLE_CNT_W-1:0] cnt_q, cnt_d;
	logic sel_q, sel_d;
	logic [pdmc_pkg::SETTLE_SEL_W-1:0] settle_sel_q, settle_sel_d;
	logic init_seen_q, init_seen_d;
	logic wake_irq_q, wake_irq_d;
	logic [PW-1:0] pins_vec;
	logic ext_wake;
	logic reset_exit;

	// Settle length for a select code; 11x is prohibited and held at the longest
	function automatic logic [pdmc_pkg::SETTLE_CNT_W-1:0] settle_len(input logic [2:0] code);
		case (code)
			3'h0: settle_len = pdmc_pkg::SETTLE_STATES_0;
			3'h1: settle_len = pdmc_pkg::SETTLE_STATES_1;
			3'h2: settle_len = pdmc_pkg::SETTLE_STATES_2;
			3'h3: settle_len = pdmc_pkg::SETTLE_STATES_3;
			default: settle_len = pdmc_pkg::SETTLE_STATES_4;
		endcase
	endfunction : settle_len

	assign pins_raw = {nmi_pin_n, irq_pin_n, key_sense_inputs, chip_init_pin_n, hw_standby_pin_n};

	pdmc_sync #(
		.W(PW),
		.INIT({PW{1'b1}})
	) u_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.pin_in(pins_raw),
		.pin_out(pins_vec)
	);

	assign pins = pins_vec;
	assign ext_wake = !pins.nmi_n || !(&pins.irq_n) || !(&pins.key_n);

	// Standby pin must be high too, else a fresh standby entry would pass for a reset exit
	assign reset_exit = state_q == pdmc_pkg::PDMC_HW_STANDBY && pins.hw_standby_n && pins.chip_init_n
		&& init_seen_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		init_seen_d = init_seen_q;
		wake_irq_d = 1'b0;
		if (!pins.hw_standby_n) begin
			state_d = pdmc_pkg::PDMC_HW_STANDBY;
			init_seen_d = 1'b0;
		end else begin
			case (state_q)
				pdmc_pkg::PDMC_RUN: begin
					if (halt_exec) begin
						state_d = sel_q ? pdmc_pkg::PDMC_SW_STANDBY : pdmc_pkg::PDMC_SLEEP;
					end
				end
				pdmc_pkg::PDMC_SLEEP: begin
					if (!pins.chip_init_n) begin
						state_d = pdmc_pkg::PDMC_HW_STANDBY;
						init_seen_d = 1'b1;
					end else if (irq_pending) begin
						state_d = pdmc_pkg::PDMC_RUN;
						wake_irq_d = 1'b1;
					end
				end
				pdmc_pkg::PDMC_SW_STANDBY: begin
					if (!pins.chip_init_n) begin
						// Reuse the reset hold path; oscillator restarts while pin low
						state_d = pdmc_pkg::PDMC_HW_STANDBY;
						init_seen_d = 1'b1;
					end else if (ext_wake) begin
						state_d = pdmc_pkg::PDMC_SETTLE;
						cnt_d = settle_len(settle_sel_q);
					end
				end
				pdmc_pkg::PDMC_SETTLE: begin
					if (!pins.chip_init_n) begin
						state_d = pdmc_pkg::PDMC_HW_STANDBY;
						init_seen_d = 1'b1;
					end else if (cnt_q <= 18'h00001) begin
						state_d = pdmc_pkg::PDMC_RUN;
						wake_irq_d = 1'b1;
					end else begin
						cnt_d = cnt_q - 18'h00001;
					end
				end
				pdmc_pkg::PDMC_HW_STANDBY: begin
					// Standby pin already high here; wait for an init pulse
					if (!pins.chip_init_n) begin
						init_seen_d = 1'b1;
					end else if (reset_exit) begin
						state_d = pdmc_pkg::PDMC_RUN;
						init_seen_d = 1'b0;
					end
				end
				default: state_d = pdmc_pkg::PDMC_RUN;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= pdmc_pkg::PDMC_RUN;
			cnt_q <= '0;
			init_seen_q <= 1'b0;
			wake_irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			init_seen_q <= init_seen_d;
			wake_irq_q <= wake_irq_d;
		end
	end

	// Writes outside run are dropped silently; a prohibited code is kept as written
	always_comb begin
		sel_d = sel_q;
		settle_sel_d = settle_sel_q;
		if (reset_exit) begin
			sel_d = 1'b0;
			settle_sel_d = pdmc_pkg::SETTLE_SEL_RST;
		end else if (select_wr && state_q == pdmc_pkg::PDMC_RUN) begin
			sel_d = select_wdata;
			settle_sel_d = settle_sel_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sel_q <= 1'b0;
			settle_sel_q <= pdmc_pkg::SETTLE_SEL_RST;
		end else begin
			sel_q <= sel_d;
			settle_sel_q <= settle_sel_d;
		end
	end

	// Per-mode controls of clock, CPU, modules and ports
	always_comb begin
		ctl = '0;
		ctl.clk_run = 1'b1;
		ctl.mod_clk_run = 1'b1;
		ctl.cpu_regs_keep = 1'b1;
		case (state_q)
			pdmc_pkg::PDMC_RUN: begin
				ctl.cpu_halt = 1'b0;
			end
			pdmc_pkg::PDMC_SLEEP: begin
				// Modules and clock keep running, only the CPU waits
				ctl.cpu_halt = 1'b1;
			end
			pdmc_pkg::PDMC_SW_STANDBY: begin
				ctl.clk_run = 1'b0;
				ctl.mod_clk_run = 1'b0;
				ctl.cpu_halt = 1'b1;
				ctl.mod_init = 1'b1;
			end
			pdmc_pkg::PDMC_SETTLE: begin
				// Oscillator runs, but nothing is clocked until the count ends
				ctl.clk_run = 1'b1;
				ctl.mod_clk_run = 1'b0;
				ctl.cpu_halt = 1'b1;
				ctl.mod_init = 1'b1;
			end
			pdmc_pkg::PDMC_HW_STANDBY: begin
				ctl.clk_run = init_seen_q;
				ctl.mod_clk_run = 1'b0;
				ctl.cpu_halt = 1'b1;
				ctl.cpu_regs_keep = 1'b0;
				ctl.mod_init = 1'b1;
				ctl.ports_hiz = !pins.hw_standby_n;
				ctl.reset_seq = reset_exit;
			end
			default: begin
				ctl.cpu_halt = 1'b0;
			end
		endcase
	end

	assign mode = state_q;
	assign standby_select_bit = sel_q;
	assign wake_settle_select = settle_sel_q;
	assign wake_irq = wake_irq_q;
endmodule : pdmc_ctrl

// *** verification/pdmc_ctrl_assertions.sv ***
// Checker for the power-down mode controller
`timescale 1ns/1ps
module pdmc_ctrl_assertions (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic halt_exec,
	input wire logic irq_pending,
	input wire logic select_wr,
	input wire logic select_wdata,
	input wire logic standby_select_bit,
	input wire pdmc_pkg::pdmc_ctl_s ctl,
	input wire pdmc_pkg::pdmc_state_e mode,
	input wire logic wake_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_halt(b);
		mode == pdmc_pkg::PDMC_RUN && halt_exec && standby_select_bit == b;
	endsequence
	a_halt_sleep: assert property (s_halt(0) |=> mode == pdmc_pkg::PDMC_SLEEP)
		else $error("no sleep");
	a_halt_soft: assert property (s_halt(1) |=> mode == pdmc_pkg::PDMC_SW_STANDBY)
		else $error("no standby");
	a_sleep_wake: assert property (mode == pdmc_pkg::PDMC_SLEEP && irq_pending |=> wake_irq)
		else $error("no wake");
	a_sel_write: assert property (mode == pdmc_pkg::PDMC_RUN && select_wr |=> standby_select_bit == $past(select_wdata))
		else $error("bad write");
	a_settle_sel: assert property (mode == pdmc_pkg::PDMC_SETTLE |-> standby_select_bit)
		else $error("select lost");
	a_soft_ctl: assert property (mode == pdmc_pkg::PDMC_SW_STANDBY |-> !ctl.clk_run && ctl.mod_init && ctl.cpu_regs_keep)
		else $error("standby controls");
	a_hard_ctl: assert property (ctl.ports_hiz |-> mode == pdmc_pkg::PDMC_HW_STANDBY && !ctl.cpu_regs_keep)
		else $error("hw controls");
	a_reset_run: assert property (ctl.reset_seq |=> mode == pdmc_pkg::PDMC_RUN && !standby_select_bit)
		else $error("no run");
endmodule : pdmc_ctrl_assertions
bind pdmc_ctrl pdmc_ctrl_assertions u_chk (.sys_clk, .srst, .halt_exec, .irq_pending, .select_wr, .select_wdata,
	.standby_select_bit, .ctl, .mode, .wake_irq);

// *** verification/pdmc_pin_model.sv ***
// Model of the external standby, init and wake pins
`timescale 1ns/1ps
module pdmc_pin_model (
	input wire logic sys_clk,
	input wire logic standby_req,
	input wire logic init_req,
	input wire logic [11:0] wake_req,
	output logic hw_standby_pin_n,
	output logic chip_init_pin_n,
	output logic [11:0] wake_n
);
	// Sole driver; pins are unknown only while reset holds the synchroniser
	always @(posedge sys_clk) begin
		hw_standby_pin_n <= !standby_req;
		// Init pulse only once standby pin is back high
		chip_init_pin_n <= !(init_req && hw_standby_pin_n);
		wake_n <= ~wake_req;
	end
endmodule : pdmc_pin_model

// *** verification/tb_top.sv ***
// Testbench for the power-down mode controller
`timescale 1ns/1ps
module tb_top;
	logic sys_clk, srst, halt_exec, irq_pending, select_wr, select_wdata, standby_req, init_req;
	logic [2:0] settle_sel_wdata, wake_settle_select;
	logic [11:0] wake_req, wake_n;
	logic hw_standby_pin_n, chip_init_pin_n, standby_select_bit, wake_irq;
	pdmc_pkg::pdmc_ctl_s ctl;
	pdmc_pkg::pdmc_state_e mode;
	int bad_count, num_checks;
	pdmc_pin_model pins (.sys_clk, .standby_req, .init_req, .wake_req, .hw_standby_pin_n, .chip_init_pin_n, .wake_n);
	pdmc_ctrl dut (.sys_clk, .srst, .halt_exec, .irq_pending, .select_wr, .select_wdata, .settle_sel_wdata,
		.nmi_pin_n(wake_n[11]), .irq_pin_n(wake_n[10:8]), .key_sense_inputs(wake_n[7:0]), .chip_init_pin_n,
		.hw_standby_pin_n, .standby_select_bit, .wake_settle_select, .ctl, .mode, .wake_irq);
	initial forever #2.5 sys_clk = ~sys_clk;
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task chk(input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wait_mode(input pdmc_pkg::pdmc_state_e m);
		for (int i = 0; i < 40 && mode !== m; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk(mode, m);
		if (mode !== m)
			report_and_stop;
	endtask : wait_mode
	task t_sleep;
		@(posedge sys_clk) halt_exec <= 1'h1;
		@(posedge sys_clk) halt_exec <= 1'h0;
		#1 chk({mode, ctl}, {pdmc_pkg::PDMC_SLEEP, 7'h78});
		@(posedge sys_clk) irq_pending <= 1'h1;
		@(posedge sys_clk) irq_pending <= 1'h0;
		#1 chk({mode, wake_irq}, {pdmc_pkg::PDMC_RUN, 1'h1});
		$display("sleep test done");
	endtask : t_sleep
	task t_soft(input logic [11:0] w);
		int n;
		repeat (8) @(posedge sys_clk);
		{select_wr, select_wdata} <= 2'h3;
		@(posedge sys_clk) {select_wr, halt_exec} <= 2'h1;
		@(posedge sys_clk) halt_exec <= 1'h0;
		#1 chk(mode, pdmc_pkg::PDMC_SW_STANDBY);
		@(posedge sys_clk) wake_req <= w;
		wait_mode(pdmc_pkg::PDMC_SETTLE);
		for (n = 0; n < 9000 && mode === pdmc_pkg::PDMC_SETTLE; n++) begin
			@(posedge sys_clk) wake_req <= 12'h000;
			#1;
		end
		chk(n, pdmc_pkg::SETTLE_STATES_0);
		if (n >= 9000)
			report_and_stop;
		chk({mode, wake_irq, standby_select_bit}, {pdmc_pkg::PDMC_RUN, 2'h3});
		$display("standby test done");
	endtask : t_soft
	task t_hard;
		@(posedge sys_clk) {select_wr, select_wdata, settle_sel_wdata} <= 5'h1d;
		@(posedge sys_clk) {select_wr, standby_req} <= 2'h1;
		#1 chk({standby_select_bit, wake_settle_select}, 4'hd);
		wait_mode(pdmc_pkg::PDMC_HW_STANDBY);
		chk(ctl, 7'h26);
		@(posedge sys_clk) standby_req <= 1'h0;
		repeat (8) @(posedge sys_clk);
		init_req <= 1'h1;
		repeat (8) @(posedge sys_clk);
		init_req <= 1'h0;
		wait_mode(pdmc_pkg::PDMC_RUN);
		chk({standby_select_bit, wake_settle_select}, 4'h0);
		$display("hw standby test done");
	endtask : t_hard
	task t_init;
		@(posedge sys_clk) halt_exec <= 1'h1;
		@(posedge sys_clk) halt_exec <= 1'h0;
		#1 chk(mode, pdmc_pkg::PDMC_SW_STANDBY);
		@(posedge sys_clk) init_req <= 1'h1;
		wait_mode(pdmc_pkg::PDMC_HW_STANDBY);
		chk({ctl.clk_run, ctl.cpu_regs_keep, ctl.reset_seq}, 3'h4);
		@(posedge sys_clk) init_req <= 1'h0;
		wait_mode(pdmc_pkg::PDMC_RUN);
		chk(standby_select_bit, 1'h0);
		$display("init wake test done");
	endtask : t_init
	initial begin
		{sys_clk, srst, halt_exec, irq_pending, select_wr, select_wdata, standby_req, init_req} = 8'h40;
		{settle_sel_wdata, wake_req} = 15'h0000;
		{bad_count, num_checks} = 64'h0;
		repeat (16) @(posedge sys_clk);
		srst <= 1'h0;
		#1 chk({mode, standby_select_bit}, {pdmc_pkg::PDMC_RUN, 1'h0});
		t_sleep;
		t_soft(12'h800);
		t_soft(12'h080);
		t_init;
		t_hard;
		report_and_stop;
	end
endmodule : tb_top
